// file: dv/mac_phy_model.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// PHY side model: receive byte stream and transmit attempt events
// ****************************************************************
module mac_phy_model
   import mac_rx_filter_pkg::*;
(
   // Clock
   input  wire logic          core_clk,
   // Receive stream and transmit events
   output var  logic          rxValid,
   output var  rx_byte_type   rxIn,
   output var  tx_event_type  txEvent
);
   // Quiet outputs at time zero
   initial begin
      rxValid = 1'b0;
      rxIn    = '0;
      txEvent = '0;
   end

   // One frame back to back; the idle byte after it clears sof and eof and inverts bad and data so stale data never matches
   task automatic send(input logic [7:0] q[$], input logic bad);
      for (int i = 0; i < q.size(); i++) begin
         @(posedge core_clk);
         rxValid <= 1'b1;
         rxIn    <= '{sof: (i == 0), eof: (i == q.size() - 1), bad: bad, data: q[i]};
      end
      @(posedge core_clk);
      rxValid <= 1'b0;
      rxIn    <= '{sof: 1'b0, eof: 1'b0, bad: ~bad, data: ~q[q.size() - 1]};
   endtask

   // One attempt outcome pulse
   task automatic attempt(input logic coll);
      @(posedge core_clk);
      txEvent <= '{collision: coll, success: ~coll};
      @(posedge core_clk);
      txEvent <= '0;
   endtask
endmodule

`default_nettype wire

// file: dv/test_mac_rx_filter_tx_retry_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

module test_mac_rx_filter_tx_retry_ctrl
   import mac_rx_filter_pkg::*;
;
   logic          core_clk;
   logic          rst;
   reg_req_type   regReq;
   logic [31:0]   regRdata;
   logic          irq;
   logic          rxValid;
   rx_byte_type   rxIn;
   logic          rxOutValid;
   rx_out_type    rxOut;
   rx_status_type rxStatus;
   logic          wakeEvent;
   tx_event_type  txEvent;
   tx_result_type txResult;
   int            n_errors;
   int            samples_checked;
   int            nDone;
   int            nKept;
   int            nRetry;
   int            nAbort;
   int            nWake;
   logic          lastAccept;
   logic [47:0]   station;
   logic [31:0]   ctrl;
   logic [31:0]   rd;
   logic [15:0]   len;
   logic [1:0]    kind;
   logic          bad;
   logic          hashAll;
   logic [9:0]    prevByte;

   // ****************************************************************
   // Instances and clock
   // ****************************************************************
   mac_rx_filter_tx_retry_ctrl i_mac_rx_filter_tx_retry_ctrl (.core_clk(core_clk), .rst(rst),
      .regReq(regReq), .regRdata(regRdata), .irq(irq), .rxValid(rxValid), .rxIn(rxIn),
      .rxOutValid(rxOutValid), .rxOut(rxOut), .rxStatus(rxStatus), .wakeEvent(wakeEvent),
      .txEvent(txEvent), .txResult(txResult));
   mac_phy_model i_mac_phy_model (.core_clk(core_clk), .rxValid(rxValid), .rxIn(rxIn),
      .txEvent(txEvent));

   // 50 ns clock
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // Output monitor: kept bytes, frame decisions, transmit results, wake pulses
   always @(posedge core_clk) begin
      if (rxOutValid === 1'b1 && rxOut.keep === 1'b1) nKept++;
      // Delivered byte must be the byte taken one edge earlier
      if (rxOutValid === 1'b1) check(32'({rxOut.sof, rxOut.eof, rxOut.data}), 32'(prevByte));
      prevByte = {rxIn.sof, rxIn.eof, rxIn.data};
      if (rxStatus.done === 1'b1) begin
         nDone++;
         lastAccept = rxStatus.accept;
      end
      if (txResult.retry === 1'b1) nRetry++;
      if (txResult.abort === 1'b1 && txResult.retryError === 1'b1) nAbort++;
      if (wakeEvent === 1'b1) nWake++;
   end

   // ****************************************************************
   // Tasks and expectations
   // ****************************************************************
   task automatic conclude();
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
         n_errors++;
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      regReq <= '0;
   endtask

   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      regReq <= '{addr: a, wdata: 32'h00000000, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      regReq <= '0;
      #1 d = regRdata;
      // Read data stands one cycle only
      @(posedge core_clk);
      #1 check(regRdata, 32'h00000000);
   endtask

   task automatic wait_done(input int was);
      for (int t = 0; t < 20 && nDone == was; t++) @(negedge core_clk);
      if (nDone == was) begin
         n_errors++;
         conclude();
      end
      @(negedge core_clk);
   endtask

   // Kind 0 own address, 1 other unicast, 2 multicast, 3 broadcast
   task automatic frame(input logic [1:0] k, input logic [15:0] l, input logic b);
      logic [7:0]  q[$];
      logic [47:0] da;
      int          n;
      da = station;
      if (k == 2'd1) da[47:40] = da[47:40] ^ 8'h80;
      if (k == 2'd2) da = {1'b0, da[46:1], 1'b1};
      if (k == 2'd3) da = 48'hFFFFFFFFFFFF;
      n = (l < MIN_PAYLOAD_LEN) ? 46 : int'(l);
      for (int i = 0; i < 6; i++) q.push_back(da[8*i +: 8]);
      for (int i = 0; i < 6; i++) q.push_back(8'($urandom));
      q.push_back(l[15:8]);
      q.push_back(l[7:0]);
      for (int i = 0; i < n + 4; i++) q.push_back(8'($urandom));
      nKept = 0;
      n = nDone;
      i_mac_phy_model.send(q, b);
      wait_done(n);
   endtask

   function automatic logic exp_accept(logic [31:0] c, logic [1:0] k, logic b, logic h);
      logic m;
      if (!c[HASH_PERFECT_BIT]) m = (k == 2'd0) ^ c[INVERSE_FILTER_BIT];
      else if (k >= 2'd2 || c[HASH_ONLY_BIT]) m = h;
      else m = (k == 2'd0);
      if (k == 2'd3) m = ~c[BROADCAST_DIS_BIT];
      return m & (~b | c[PASS_BAD_FRAMES_BIT]);
   endfunction

   function automatic logic [31:0] exp_kept(logic [31:0] c, logic [15:0] l);
      if (c[PAD_STRIP_BIT] && l < MIN_PAYLOAD_LEN) return 32'(l) + 32'h0000000E;
      return (l < MIN_PAYLOAD_LEN) ? 32'h00000040 : 32'(l) + 32'h00000012;
   endfunction

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      rst = 1'b1;
      regReq = '0;
      void'($urandom(32'hA62A09CC));
      station = 48'({$urandom, $urandom}) & 48'hFFFFFFFFFFFE;
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      reg_rd(REG_CONTROL, rd);
      check(rd, CONTROL_RESET);
      reg_rd(8'hFF, rd);
      check(rd, 32'h00000000);
      reg_wr(REG_CONTROL, 32'hFFFFFFFF);
      reg_rd(REG_CONTROL, rd);
      check(rd, CONTROL_RW_MASK);
      reg_wr(REG_ADDR_LOW, station[31:0]);
      reg_wr(REG_ADDR_HIGH, {16'hFFFF, station[47:32]});
      reg_rd(REG_ADDR_HIGH, rd);
      check(rd, {16'h0000, station[47:32]});
      // Random filter modes, frame kinds, lengths and bad flags
      for (int f = 0; f < 44; f++) begin
         ctrl = $urandom & CONTROL_RW_MASK;
         kind = 2'($urandom);
         len = (f < 4) ? 16'(44 + f) : 16'($urandom_range(60));
         bad = ($urandom_range(3) == 0);
         hashAll = 1'($urandom);
         reg_wr(REG_CONTROL, ctrl);
         reg_wr(REG_HASH_HIGH, {32{hashAll}});
         reg_wr(REG_HASH_LOW, {32{hashAll}});
         frame(kind, len, bad);
         check(lastAccept, exp_accept(ctrl, kind, bad, hashAll));
         check(32'(nKept), exp_kept(ctrl, len));
         check(rxStatus.multicast, kind[1]);
         check(rxStatus.broadcast, kind == 2'd3);
      end
      // Broadcast wake despite broadcast-disable
      reg_wr(REG_WAKE_CTRL, 32'h00000004);
      reg_wr(REG_CONTROL, 32'h00000800);
      nWake = 0;
      frame(2'd3, 16'h0030, 1'b0);
      check(32'(nWake), 32'h00000001);
      check(lastAccept, 1'b0);
      reg_wr(REG_WAKE_CTRL, 32'h00000000);
      // Dropped-frame interrupt: masked, unmasked, cleared
      reg_wr(REG_CONTROL, 32'h00000000);
      reg_wr(REG_IRQ_STATUS, 32'h00000007);
      reg_wr(REG_IRQ_MASK, 32'h00000000);
      frame(2'd1, 16'h0030, 1'b0);
      check(irq, 1'b0);
      reg_rd(REG_IRQ_STATUS, rd);
      check(rd, 32'h00000001);
      reg_wr(REG_IRQ_MASK, 32'h00000001);
      repeat (2) @(negedge core_clk);
      check(irq, 1'b1);
      reg_wr(REG_IRQ_STATUS, 32'h00000001);
      repeat (2) @(negedge core_clk);
      check(irq, 1'b0);
      // Retries: success restarts the count, 16th collision aborts
      nRetry = 0;
      nAbort = 0;
      repeat (3) i_mac_phy_model.attempt(1'b1);
      i_mac_phy_model.attempt(1'b0);
      repeat (16) i_mac_phy_model.attempt(1'b1);
      repeat (2) @(negedge core_clk);
      check(32'(nRetry), 32'h00000012);
      check(32'(nAbort), 32'h00000001);
      reg_wr(REG_CONTROL, 32'h00000400);
      i_mac_phy_model.attempt(1'b1);
      repeat (2) @(negedge core_clk);
      check(32'(nRetry), 32'h00000012);
      check(32'(nAbort), 32'h00000002);
      reg_rd(REG_IRQ_STATUS, rd);
      check(rd, 32'h00000004);
      conclude();
   end
endmodule

`default_nettype wire

// file: hw/mac_rx_filter_pkg.sv
`default_nettype none

package mac_rx_filter_pkg;

   // ****************************************************************
   // Register indices on the plain register port
   // ****************************************************************
   localparam logic [7:0]  REG_CONTROL      = 8'h01;
   localparam logic [7:0]  REG_ADDR_HIGH    = 8'h02;
   localparam logic [7:0]  REG_ADDR_LOW     = 8'h03;
   localparam logic [7:0]  REG_HASH_HIGH    = 8'h04;
   localparam logic [7:0]  REG_HASH_LOW     = 8'h05;
   localparam logic [7:0]  REG_WAKE_CTRL    = 8'h0C;
   localparam logic [7:0]  REG_IRQ_STATUS   = 8'h20;
   localparam logic [7:0]  REG_IRQ_MASK     = 8'h21;

   // ****************************************************************
   // Control register fields and reset values
   // ****************************************************************
   localparam int unsigned INVERSE_FILTER_BIT   = 17;
   localparam int unsigned PASS_BAD_FRAMES_BIT  = 16;
   localparam int unsigned HASH_ONLY_BIT        = 15;
   localparam int unsigned HASH_PERFECT_BIT     = 13;
   localparam int unsigned BROADCAST_DIS_BIT    = 11;
   localparam int unsigned RETRY_DISABLE_BIT    = 10;
   localparam int unsigned PAD_STRIP_BIT        = 8;
   localparam logic [31:0] CONTROL_RW_MASK      = 32'h0003AD00;
   localparam logic [31:0] CONTROL_RESET        = 32'h00000000;
   localparam logic [31:0] ADDR_HIGH_MASK       = 32'h0000FFFF;
   localparam logic [31:0] WAKE_CTRL_MASK       = 32'h00000004;
   localparam int unsigned WAKE_EN_BIT          = 2;
   localparam logic [31:0] REG_RESET            = 32'h00000000;

   // ****************************************************************
   // Interrupt status layout
   // ****************************************************************
   localparam int unsigned IRQ_W                = 3;
   localparam int unsigned IRQ_RX_DROP          = 0;
   localparam int unsigned IRQ_WAKE             = 1;
   localparam int unsigned IRQ_TX_RETRY_ERR     = 2;
   localparam logic [2:0]  IRQ_RESET            = 3'h0;

   // ****************************************************************
   // Frame layout, hash and retry constants
   // ****************************************************************
   localparam logic [15:0] IDX_LEN_HIGH         = 16'h000C;
   localparam logic [15:0] IDX_LEN_LOW          = 16'h000D;
   localparam logic [15:0] HEADER_LEN           = 16'h000E;
   localparam logic [15:0] DA_LEN               = 16'h0006;
   localparam logic [15:0] MIN_PAYLOAD_LEN      = 16'h002E;
   localparam logic [15:0] IDX_MAX              = 16'hFFFF;
   localparam logic [31:0] CRC_INIT             = 32'hFFFFFFFF;
   localparam logic [31:0] CRC_POLY             = 32'hEDB88320;
   localparam logic [4:0]  TX_ATTEMPT_MAX       = 5'h10;
   localparam logic [4:0]  TX_ATTEMPT_FIRST     = 5'h01;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_type;

   typedef struct packed {
      logic       sof;
      logic       eof;
      logic       bad;
      logic [7:0] data;
   } rx_byte_type;

   typedef struct packed {
      logic       sof;
      logic       eof;
      logic       keep;
      logic [7:0] data;
   } rx_out_type;

   typedef struct packed {
      logic done;
      logic accept;
      logic broadcast;
      logic multicast;
   } rx_status_type;

   typedef struct packed {
      logic collision;
      logic success;
   } tx_event_type;

   typedef struct packed {
      logic retry;
      logic abort;
      logic retryError;
   } tx_result_type;

endpackage

`default_nettype wire

// file: hw/mac_rx_filter_tx_retry_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Inverse bit flips the perfect address result; ignored in hash modes
// - Pass-bad bit accepts runt and collided frames that pass address filtering
// - Hash-only bit with hash/perfect set hashes individual and multicast addresses alike
// - Hash/perfect clear: compare destination with the station address
// - Hash/perfect set: multicast destinations checked against the hash table
// - Hash/perfect set, hash-only clear: individual addresses still compared exactly
// - Broadcast-disable set drops broadcast frames; clear forwards them all except bad ones while pass-bad is clear
// - Wake detection enabled: broadcast frame not flagged bad wakes despite broadcast-disable
// - Retry-disable set: one attempt, collision drops frame, flags retry error
// - Retry-disable clear: up to 16 attempts before retry error
// - Pad strip with length under 46 removes pad bytes and FCS
// - Pad strip with length 46 or more leaves the frame whole
// - Pad strip clear delivers every frame unmodified
// - First destination bit one means multicast, else individual
module mac_rx_filter_tx_retry_ctrl
   import mac_rx_filter_pkg::*;
(
   // Clock and reset
   input  wire logic          core_clk,
   input  wire logic          rst,
   // Register port
   input  wire reg_req_type   regReq,
   output var  logic [31:0]   regRdata,
   output var  logic          irq,
   // Receive byte stream
   input  wire logic          rxValid,
   input  wire rx_byte_type   rxIn,
   output var  logic          rxOutValid,
   output var  rx_out_type    rxOut,
   output var  rx_status_type rxStatus,
   output var  logic          wakeEvent,
   // Transmit attempt events
   input  wire tx_event_type  txEvent,
   output var  tx_result_type txResult
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [31:0]        control_ff;
   logic [31:0]        addrHigh_ff;
   logic [31:0]        addrLow_ff;
   logic [31:0]        hashHigh_ff;
   logic [31:0]        hashLow_ff;
   logic [31:0]        wakeCtrl_ff;
   logic [IRQ_W-1:0]   irqStatus_ff;
   logic [IRQ_W-1:0]   irqMask_ff;
   logic [IRQ_W-1:0]   nxt_irqStatus;
   logic [IRQ_W-1:0]   irqEvents;
   logic [IRQ_W-1:0]   irqClear;
   logic [31:0]        regRdata_ff;
   logic [31:0]        nxt_regRdata;
   logic               irq_ff;
   logic [15:0]        byteIdx_ff;
   logic [15:0]        curIdx;
   logic [47:0]        da_ff;
   logic [31:0]        crc_ff;
   logic [15:0]        lenField_ff;
   logic [15:0]        keepLimit;
   logic               stripActive;
   logic               keepByte;
   logic               rxOutValid_ff;
   rx_out_type         rxOut_ff;
   rx_status_type      rxStatus_ff;
   logic               wake_ff;
   logic               isMulticast;
   logic               isBroadcast;
   logic               daMatch;
   logic               hashHit;
   logic               perfectPass;
   logic               addrPass;
   logic               frameAccept;
   logic               frameEnd;
   logic               wakeHit;
   logic [4:0]         attemptCnt_ff;
   logic               giveUp;
   tx_result_type      txResult_ff;
   logic               inverseEn;
   logic               pass_bad_frames;
   logic               hashOnly;
   logic               hashPerfect;
   logic               bcastDis;
   logic               retryDis;
   logic               padStripEn;
   logic               wakeEn;

   // Control fields
   assign inverseEn   = control_ff[INVERSE_FILTER_BIT];
   assign pass_bad_frames     = control_ff[PASS_BAD_FRAMES_BIT];
   assign hashOnly    = control_ff[HASH_ONLY_BIT];
   assign hashPerfect = control_ff[HASH_PERFECT_BIT];
   assign bcastDis    = control_ff[BROADCAST_DIS_BIT];
   assign retryDis    = control_ff[RETRY_DISABLE_BIT];
   assign padStripEn  = control_ff[PAD_STRIP_BIT];
   assign wakeEn      = wakeCtrl_ff[WAKE_EN_BIT];

   // ****************************************************************
   // Register port
   // ****************************************************************

   // Software writable registers; unwritable bits stay zero
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         control_ff  <= CONTROL_RESET;
         addrHigh_ff <= REG_RESET;
         addrLow_ff  <= REG_RESET;
         hashHigh_ff <= REG_RESET;
         hashLow_ff  <= REG_RESET;
         wakeCtrl_ff <= REG_RESET;
         irqMask_ff  <= IRQ_RESET;
      end else if (regReq.wr) begin
         case (regReq.addr)
            REG_CONTROL:    control_ff  <= regReq.wdata & CONTROL_RW_MASK;
            REG_ADDR_HIGH:  addrHigh_ff <= regReq.wdata & ADDR_HIGH_MASK;
            REG_ADDR_LOW:   addrLow_ff  <= regReq.wdata;
            REG_HASH_HIGH:  hashHigh_ff <= regReq.wdata;
            REG_HASH_LOW:   hashLow_ff  <= regReq.wdata;
            REG_WAKE_CTRL:  wakeCtrl_ff <= regReq.wdata & WAKE_CTRL_MASK;
            REG_IRQ_MASK:   irqMask_ff  <= regReq.wdata[IRQ_W-1:0];
            default:        ;
         endcase
      end
   end

   // Read mux; unmapped indices read zero
   always_comb begin
      nxt_regRdata = REG_RESET;
      if (regReq.rd) begin
         case (regReq.addr)
            REG_CONTROL:    nxt_regRdata = control_ff;
            REG_ADDR_HIGH:  nxt_regRdata = addrHigh_ff;
            REG_ADDR_LOW:   nxt_regRdata = addrLow_ff;
            REG_HASH_HIGH:  nxt_regRdata = hashHigh_ff;
            REG_HASH_LOW:   nxt_regRdata = hashLow_ff;
            REG_WAKE_CTRL:  nxt_regRdata = wakeCtrl_ff;
            REG_IRQ_STATUS: nxt_regRdata = {29'h0, irqStatus_ff};
            REG_IRQ_MASK:   nxt_regRdata = {29'h0, irqMask_ff};
            default:        nxt_regRdata = REG_RESET;
         endcase
      end
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         regRdata_ff <= REG_RESET;
      end else begin
         regRdata_ff <= nxt_regRdata;
      end
   end

   // ****************************************************************
   // Interrupts
   // ****************************************************************

   // Write-one-to-clear; a new event in the same cycle wins
   always_comb begin
      irqEvents = IRQ_RESET;
      irqEvents[IRQ_RX_DROP]      = frameEnd & ~frameAccept;
      irqEvents[IRQ_WAKE]         = wakeHit;
      irqEvents[IRQ_TX_RETRY_ERR] = txEvent.collision & giveUp;
      irqClear = (regReq.wr && regReq.addr == REG_IRQ_STATUS) ?
                 regReq.wdata[IRQ_W-1:0] : IRQ_RESET;
      nxt_irqStatus = (irqStatus_ff & ~irqClear) | irqEvents;
   end

   // Sticky status and level interrupt
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irqStatus_ff <= IRQ_RESET;
         irq_ff       <= 1'b0;
      end else begin
         irqStatus_ff <= nxt_irqStatus;
         irq_ff       <= |(nxt_irqStatus & irqMask_ff);
      end
   end

   // ****************************************************************
   // Receive address filter
   // ****************************************************************

   // Reflected CRC over one byte, LSB first
   function automatic logic [31:0] crcByte(input logic [31:0] crcIn, input logic [7:0] d);
      logic [31:0] c;
      c = crcIn;
      for (int i = 0; i < 8; i++) begin
         c = (c[0] ^ d[i]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction

   assign curIdx = rxIn.sof ? 16'h0000 : byteIdx_ff;

   // Byte position, destination address and its hash
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         byteIdx_ff  <= 16'h0000;
         da_ff       <= 48'h000000000000;
         crc_ff      <= CRC_INIT;
         lenField_ff <= 16'h0000;
      end else if (rxValid) begin
         byteIdx_ff <= (curIdx == IDX_MAX) ? curIdx : curIdx + 16'h0001;
         if (curIdx < DA_LEN) begin
            da_ff[8*curIdx[2:0] +: 8] <= rxIn.data;
            crc_ff <= crcByte(rxIn.sof ? CRC_INIT : crc_ff, rxIn.data);
         end
         if (curIdx == IDX_LEN_HIGH) begin
            lenField_ff[15:8] <= rxIn.data;
         end
         if (curIdx == IDX_LEN_LOW) begin
            lenField_ff[7:0] <= rxIn.data;
         end
      end
   end

   // Address classification and match
   assign isMulticast = da_ff[0];
   assign isBroadcast = &da_ff;
   assign daMatch     = (da_ff == {addrHigh_ff[15:0], addrLow_ff});
   assign hashHit     = crc_ff[31] ? hashHigh_ff[crc_ff[30:26]] : hashLow_ff[crc_ff[30:26]];

   // Filter mode selection
   always_comb begin
      perfectPass = inverseEn ? ~daMatch : daMatch;
      if (!hashPerfect) begin
         addrPass = perfectPass;
      end else if (isMulticast) begin
         addrPass = hashHit;
      end else if (hashOnly) begin
         addrPass = hashHit;
      end else begin
         addrPass = daMatch;
      end
      if (isBroadcast) begin
         addrPass = ~bcastDis;
      end
   end

   assign frameEnd    = rxValid & rxIn.eof;
   assign frameAccept = addrPass & (~rxIn.bad | pass_bad_frames);
   assign wakeHit     = frameEnd & wakeEn & isBroadcast & ~rxIn.bad;

   // ****************************************************************
   // Pad stripping
   // ****************************************************************

   // Short frames keep header plus length bytes only; FCS goes too
   assign keepLimit   = HEADER_LEN + lenField_ff;
   assign stripActive = padStripEn & (lenField_ff < MIN_PAYLOAD_LEN)
                        & (curIdx >= HEADER_LEN);
   assign keepByte    = ~(stripActive & (curIdx >= keepLimit));

   // Delivered stream and frame verdict, one cycle behind the input
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rxOutValid_ff <= 1'b0;
         rxOut_ff      <= '0;
         rxStatus_ff   <= '0;
         wake_ff       <= 1'b0;
      end else begin
         rxOutValid_ff    <= rxValid;
         rxOut_ff.sof     <= rxIn.sof;
         rxOut_ff.eof     <= rxIn.eof;
         rxOut_ff.keep    <= keepByte;
         rxOut_ff.data    <= rxIn.data;
         rxStatus_ff.done <= frameEnd;
         wake_ff          <= wakeHit;
         if (frameEnd) begin
            rxStatus_ff.accept    <= frameAccept;
            rxStatus_ff.broadcast <= isBroadcast;
            rxStatus_ff.multicast <= isMulticast;
         end
      end
   end

   // ****************************************************************
   // Transmit retry control
   // ****************************************************************

   // Abort when retries are off or the attempt budget is spent
   assign giveUp = retryDis | (attemptCnt_ff >= TX_ATTEMPT_MAX);

   // Attempt counter per frame and retry verdicts
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         attemptCnt_ff <= TX_ATTEMPT_FIRST;
         txResult_ff   <= '0;
      end else begin
         txResult_ff <= '0;
         if (txEvent.collision) begin
            if (giveUp) begin
               attemptCnt_ff          <= TX_ATTEMPT_FIRST;
               txResult_ff.abort      <= 1'b1;
               txResult_ff.retryError <= 1'b1;
            end else begin
               attemptCnt_ff     <= attemptCnt_ff + 5'h01;
               txResult_ff.retry <= 1'b1;
            end
         end else if (txEvent.success) begin
            attemptCnt_ff <= TX_ATTEMPT_FIRST;
         end
      end
   end

   // Outputs
   assign regRdata   = regRdata_ff;
   assign irq        = irq_ff;
   assign rxOutValid = rxOutValid_ff;
   assign rxOut      = rxOut_ff;
   assign rxStatus   = rxStatus_ff;
   assign wakeEvent  = wake_ff;
   assign txResult   = txResult_ff;

   // ****************************************************************
   // Checks
   // ****************************************************************

   a_inverse_perfect: assert property (@(posedge core_clk) disable iff (rst)
      frameEnd && !hashPerfect && !isBroadcast && !rxIn.bad && inverseEn
      |=> rxStatus.accept == !$past(daMatch))
      else $error("inverse perfect filter result wrong");

   a_bad_frame_drop: assert property (@(posedge core_clk) disable iff (rst)
      frameEnd && rxIn.bad && !pass_bad_frames |=> rxStatus.done && !rxStatus.accept)
      else $error("bad frame accepted without pass-bad");

   a_hash_only_ia: assert property (@(posedge core_clk) disable iff (rst)
      frameEnd && hashPerfect && hashOnly && !isBroadcast && !rxIn.bad
      |=> rxStatus.accept == $past(hashHit))
      else $error("hash-only filter result wrong");

   a_perfect_ia: assert property (@(posedge core_clk) disable iff (rst)
      frameEnd && hashPerfect && !hashOnly && !isMulticast && !rxIn.bad
      |=> rxStatus.accept == $past(daMatch))
      else $error("individual address not perfectly filtered");

   a_broadcast_disable_reject: assert property (@(posedge core_clk) disable iff (rst)
      frameEnd && isBroadcast && bcastDis |=> !rxStatus.accept ##1 !rxStatus.done)
      else $error("broadcast accepted while disabled");

   a_broadcast_disable_wake: assert property (@(posedge core_clk) disable iff (rst)
      frameEnd && isBroadcast && wakeEn && !rxIn.bad |=> wakeEvent ##1 irqStatus_ff[IRQ_WAKE])
      else $error("broadcast wake frame missed");

   a_retry_dis_abort: assert property (@(posedge core_clk) disable iff (rst)
      txEvent.collision && retryDis |=> txResult.abort && txResult.retryError && !txResult.retry)
      else $error("collision with retries off did not abort");

   a_retry_budget: assert property (@(posedge core_clk) disable iff (rst)
      txEvent.collision && !retryDis
      |=> (txResult.abort == ($past(attemptCnt_ff) == TX_ATTEMPT_MAX))
          && (txResult.retry != txResult.abort))
      else $error("retry budget of sixteen attempts broken");

   a_pad_strip: assert property (@(posedge core_clk) disable iff (rst)
      rxValid && padStripEn && !rxIn.sof && lenField_ff < MIN_PAYLOAD_LEN
      && curIdx >= HEADER_LEN + lenField_ff && curIdx >= HEADER_LEN |=> rxOutValid && !rxOut.keep)
      else $error("pad or FCS byte not stripped");

   a_no_strip: assert property (@(posedge core_clk) disable iff (rst)
      rxValid && !padStripEn |=> rxOutValid && rxOut.keep && rxOut.data == $past(rxIn.data))
      else $error("frame modified with pad strip off");
endmodule

`default_nettype wire
